/* File: src/rrs_exec.v */
// Execution core for return, rotate, sleep and subtract operations.
// Assumes the stack top is valid whenever a pop is requested.
`timescale 1ns/10ps
`include "rrs_map.vh"
module rrs_exec (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire [7:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output wire avs_waitrequest_o,
    input wire [14:0] stack_top_i,
    output wire stack_pop_o,
    output wire [14:0] pc_o,
    output wire halted_o,
    output wire osc_stop_o
);
    // Sequencer states; EXEC is the first execute cycle of every command, RET2 the second cycle of return.
    localparam S_IDLE = 2'b00;
    localparam S_EXEC = 2'b01;
    localparam S_RET2 = 2'b10;

    reg [1:0] state_q;
    reg [23:0] cmd_q;
    reg [7:0] acc_q;
    reg [14:0] pc_q;
    reg carry_q;
    reg nibc_q;
    reg zero_q;
    reg power_down_flag_q;
    reg watchdog_expiry_flag_q;
    reg halted_q;
    reg [7:0] watchdog_counter_q;
    reg [7:0] prescale_q;
    reg [6:0] fptr_q;
    reg [7:0] file_mem [0:`RRS_FILE_DEPTH-1];

    wire rd_take;
    wire wr_fire;
    wire busy;
    wire [2:0] op;
    wire dest;
    wire [6:0] faddr;
    wire [7:0] lit;
    wire [7:0] alu_res;
    wire alu_carry;
    wire alu_nibc;
    wire alu_zero;
    wire [31:0] wmerge;
    wire [7:0] status_byte;
    wire [31:0] cmd_merge;
    wire exec_now;
    wire file_wb;
    wire sleep_now;
    wire pre_wrap;
    wire wr_fdata;

    ////////////////////////////////////////////////////////////////////////
    // Merges write data into an old word under the byte enables.
    function [31:0] be_merge;
        input [31:0] old_w;
        input [31:0] new_w;
        input [3:0] be;
        integer i;
        begin
            be_merge = old_w;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    be_merge[i*8 +: 8] = new_w[i*8 +: 8];
                end
            end
        end
    endfunction

    // Operations whose result may be written back to the file.
    function is_file_op;
        input [2:0] op_v;
        begin
            is_file_op = (op_v == `RRS_OP_ROR) || (op_v == `RRS_OP_ROL) ||
                (op_v == `RRS_OP_FSUB);
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command fields and status outputs.
    assign busy = (state_q != S_IDLE);
    assign op = cmd_q[`RRS_CMD_OP_HI:`RRS_CMD_OP_LO];
    assign dest = cmd_q[`RRS_CMD_DEST];
    assign faddr = cmd_q[`RRS_CMD_FA_HI:`RRS_CMD_FA_LO];
    assign lit = cmd_q[`RRS_CMD_LIT_HI:`RRS_CMD_LIT_LO];
    assign pc_o = pc_q;
    assign halted_o = halted_q;
    assign osc_stop_o = halted_q;
    assign stack_pop_o = (state_q == S_EXEC) && (op == `RRS_OP_RET);
    assign exec_now = (state_q == S_EXEC);
    // Destination bit steers the file write-back.
    assign file_wb = exec_now && (dest != `RRS_DEST_ACC) && is_file_op(op);
    // Sleep clears the watchdog in its execute cycle.
    assign sleep_now = exec_now && (op == `RRS_OP_SLEEP);
    // Last count of the prescaler, after which the counter steps.
    assign pre_wrap = (prescale_q == `RRS_PRE_MAX);
    assign wr_fdata = wr_fire && (avs_address_i == `RRS_OFS_FDATA);

    // Status word as software reads it; bit 7 reads zero.
    assign status_byte = {1'b0, halted_q, busy, watchdog_expiry_flag_q,
                          power_down_flag_q, zero_q, nibc_q, carry_q};

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, held off while a command runs.
    rrs_avl_slave u_slave (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .read_i(avs_read_i),
        .write_i(avs_write_i),
        .hold_i(busy),
        .waitrequest_o(avs_waitrequest_o),
        .rd_take_o(rd_take),
        .wr_fire_o(wr_fire)
    );

    // Rotate and subtract datapath; the file operand is read directly.
    rrs_alu u_alu (
        .op_i(op),
        .carry_i(carry_q),
        .acc_i(acc_q),
        .freg_i(file_mem[faddr]),
        .lit_i(lit),
        .res_o(alu_res),
        .carry_o(alu_carry),
        .nibc_o(alu_nibc),
        .zero_o(alu_zero)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data is captured one edge before the access completes.
    // The master sees the register as it stood at the acknowledge edge.
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= 32'h00000000;
        end else if (rd_take) begin
            if (avs_address_i == `RRS_OFS_CMD) begin
                avs_readdata_o <= {8'h00, cmd_q};
            end else if (avs_address_i == `RRS_OFS_ACC) begin
                avs_readdata_o <= {24'h000000, acc_q};
            end else if (avs_address_i == `RRS_OFS_STATUS) begin
                avs_readdata_o <= {24'h000000, status_byte};
            end else if (avs_address_i == `RRS_OFS_PC) begin
                avs_readdata_o <= {17'h00000, pc_q};
            end else if (avs_address_i == `RRS_OFS_FPTR) begin
                avs_readdata_o <= {25'h0000000, fptr_q};
            end else if (avs_address_i == `RRS_OFS_FDATA) begin
                // File contents are unknown until first written.
                avs_readdata_o <= {24'h000000, file_mem[fptr_q]};
            end else if (avs_address_i == `RRS_OFS_WDOG) begin
                avs_readdata_o <= {16'h0000, prescale_q, watchdog_counter_q};
            end else begin
                avs_readdata_o <= 32'h00000000;
            end
        end
    end

    // Lane-masked write data for the narrow fields.
    assign wmerge = be_merge(32'h00000000, avs_writedata_i, avs_byteenable_i);
    // Command word merged under the lanes; only its low three bytes are kept.
    assign cmd_merge = be_merge({8'h00, cmd_q}, avs_writedata_i,
        avs_byteenable_i);

    ////////////////////////////////////////////////////////////////////////
    // File registers: bus writes only while idle, so no clash with execution.
    // File memory has no reset; software writes a register before use.
    always @(posedge core_clk_i) begin
        if (wr_fdata && avs_byteenable_i[0]) begin
            file_mem[fptr_q] <= avs_writedata_i[7:0];
        end else if (file_wb) begin
            // Destination one writes back to the file.
            file_mem[faddr] <= alu_res;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Watchdog counter runs from its prescaler until sleep clears both.
    // Both stay frozen while halted, gated off by the halted flag while the clock keeps running.
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            watchdog_counter_q <= `RRS_WDOG_CLR;
            prescale_q <= `RRS_PRE_CLR;
        end else if (sleep_now) begin
            watchdog_counter_q <= `RRS_WDOG_CLR;
            prescale_q <= `RRS_PRE_CLR;
        end else if (!halted_q) begin
            prescale_q <= prescale_q + `RRS_PRE_STEP;
            if (pre_wrap) begin
                watchdog_counter_q <= watchdog_counter_q + `RRS_WDOG_STEP;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command sequencer and architectural state.
    // A command write lands while idle and executes at the next edge.
    // Return spends a second cycle, sampling the stack top at its end.
    // While halted a command write completes on the bus but is dropped.
    // Flag writes are taken only while idle, so no race with a result.
    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_IDLE;
            cmd_q <= 24'h000000;
            acc_q <= 8'h00;
            pc_q <= `RRS_PC_RST;
            carry_q <= 1'b0;
            nibc_q <= 1'b0;
            zero_q <= 1'b0;
            power_down_flag_q <= `RRS_PDN_RST;
            watchdog_expiry_flag_q <= `RRS_WDX_RST;
            halted_q <= 1'b0;
            fptr_q <= 7'h00;
        end else begin
            case (state_q)
                S_IDLE: begin
                    if (wr_fire) begin
                        if (avs_address_i == `RRS_OFS_CMD) begin
                            if (!halted_q) begin
                                cmd_q <= cmd_merge[23:0];
                                state_q <= S_EXEC;
                            end
                        end else if (avs_address_i == `RRS_OFS_ACC) begin
                            if (avs_byteenable_i[0]) begin
                                acc_q <= wmerge[7:0];
                            end
                        end else if (avs_address_i == `RRS_OFS_STATUS) begin
                            if (avs_byteenable_i[0]) begin
                                carry_q <= wmerge[`RRS_ST_CARRY];
                                nibc_q <= wmerge[`RRS_ST_NIBC];
                                zero_q <= wmerge[`RRS_ST_ZERO];
                            end
                        end else if (avs_address_i == `RRS_OFS_FPTR) begin
                            if (avs_byteenable_i[0]) begin
                                fptr_q <= wmerge[6:0];
                            end
                        end
                    end
                end
                S_EXEC: begin
                    state_q <= S_IDLE;
                    case (op)
                        `RRS_OP_RET: begin
                            // Second cycle loads the program counter.
                            state_q <= S_RET2;
                        end
                        `RRS_OP_ROR, `RRS_OP_ROL: begin
                            carry_q <= alu_carry;
                            if (dest == `RRS_DEST_ACC) begin
                                acc_q <= alu_res;
                            end
                            pc_q <= pc_q + `RRS_PC_STEP;
                        end
                        `RRS_OP_SLEEP: begin
                            power_down_flag_q <= 1'b0;
                            watchdog_expiry_flag_q <= 1'b1;
                            // Halt the processor.
                            // Only a reset leaves the halted state.
                            halted_q <= 1'b1;
                            pc_q <= pc_q + `RRS_PC_STEP;
                        end
                        `RRS_OP_LSUB, `RRS_OP_FSUB: begin
                            carry_q <= alu_carry;
                            nibc_q <= alu_nibc;
                            zero_q <= alu_zero;
                            if ((op == `RRS_OP_LSUB) ||
                                    (dest == `RRS_DEST_ACC)) begin
                                acc_q <= alu_res;
                            end
                            pc_q <= pc_q + `RRS_PC_STEP;
                        end
                        default: begin
                            state_q <= S_IDLE;
                        end
                    endcase
                end
                S_RET2: begin
                    // Program counter from stack top, flags kept.
                    pc_q <= stack_top_i;
                    state_q <= S_IDLE;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // rrs_exec

/* File: inc/rrs_map.vh */
// Constants for the return, rotate, sleep and subtract execution block.
// Assumes an 8-bit Avalon-MM byte address bus and one core clock.
// Overview of operation
// - Return loads popped stack top into pc over two cycles; flags kept.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - File address is 0 to 127; destination 0 means accumulator, 1 file.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Sleep clears the power-down flag and sets the watchdog expiry flag.
// - Sleep clears watchdog and prescaler, then halts with clock stopped.
// - Literal minus acc into acc; updates carry, nibble carry and zero.
// - File minus acc to chosen destination; updates the same three flags.
`ifndef RRS_MAP_VH
`define RRS_MAP_VH

`define RRS_OFS_CMD 8'h00
`define RRS_OFS_ACC 8'h04
`define RRS_OFS_STATUS 8'h08
`define RRS_OFS_PC 8'h0c
`define RRS_OFS_FPTR 8'h10
`define RRS_OFS_FDATA 8'h14
`define RRS_OFS_WDOG 8'h18

`define RRS_OP_NONE 3'h0
`define RRS_OP_RET 3'h1
`define RRS_OP_ROR 3'h2
`define RRS_OP_ROL 3'h3
`define RRS_OP_SLEEP 3'h4
`define RRS_OP_LSUB 3'h5
`define RRS_OP_FSUB 3'h6

`define RRS_CMD_OP_LO 0
`define RRS_CMD_OP_HI 2
`define RRS_CMD_DEST 3
`define RRS_CMD_FA_LO 4
`define RRS_CMD_FA_HI 10
`define RRS_CMD_LIT_LO 16
`define RRS_CMD_LIT_HI 23

`define RRS_ST_CARRY 0
`define RRS_ST_NIBC 1
`define RRS_ST_ZERO 2
`define RRS_ST_PDN 3
`define RRS_ST_WDX 4
`define RRS_ST_BUSY 5
`define RRS_ST_HALT 6

`define RRS_DEST_ACC 1'b0
`define RRS_PDN_RST 1'b1
`define RRS_WDX_RST 1'b1
`define RRS_WDOG_CLR 8'h00
`define RRS_PRE_CLR 8'h00
`define RRS_PRE_STEP 8'h01
`define RRS_PRE_MAX 8'hff
`define RRS_WDOG_STEP 8'h01
`define RRS_PC_RST 15'h0000
`define RRS_PC_STEP 15'h0001
`define RRS_FILE_DEPTH 128
`define RRS_RET_CYCLES 2

`endif

/* File: src/rrs_alu.v */
// Combinational datapath for rotate and subtract operations.
// Assumes operands are stable for the cycle in which the result is used.
`timescale 1ns/10ps
`include "rrs_map.vh"
module rrs_alu (
    input wire [2:0] op_i,
    input wire carry_i,
    input wire [7:0] acc_i,
    input wire [7:0] freg_i,
    input wire [7:0] lit_i,
    output reg [7:0] res_o,
    output reg carry_o,
    output reg nibc_o,
    output wire zero_o
);
    wire [7:0] minuend;
    wire [8:0] diff;
    wire [4:0] ndiff;

    assign minuend = (op_i == `RRS_OP_LSUB) ? lit_i : freg_i;
    assign diff = {1'b0, minuend} - {1'b0, acc_i};
    assign ndiff = {1'b0, minuend[3:0]} - {1'b0, acc_i[3:0]};
    assign zero_o = (res_o == 8'h00);

    always @* begin
        res_o = diff[7:0];
        carry_o = ~diff[8];
        nibc_o = ~ndiff[4];
        case (op_i)
            `RRS_OP_ROR: begin
                res_o = {carry_i, freg_i[7:1]};
                carry_o = freg_i[0];
            end
            `RRS_OP_ROL: begin
                res_o = {freg_i[6:0], carry_i};
                carry_o = freg_i[7];
            end
            default: begin
                // Borrow is inverted into carry and nibble carry.
                res_o = diff[7:0];
            end
        endcase
    end
endmodule // rrs_alu

/* File: src/rrs_avl_slave.v */
// Avalon-MM handshake: one wait state per access, stalled while core busy.
// Assumes read and write are never high together.
`timescale 1ns/10ps
module rrs_avl_slave (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire read_i,
    input wire write_i,
    input wire hold_i,
    output wire waitrequest_o,
    output wire rd_take_o,
    output wire wr_fire_o
);
    reg ack_q;
    wire ack_d;

    assign ack_d = (read_i | write_i) & ~ack_q & ~hold_i;
    assign waitrequest_o = (read_i | write_i) & ~ack_q;
    assign rd_take_o = ack_d & read_i;
    assign wr_fire_o = write_i & ack_q;

    always @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end
endmodule // rrs_avl_slave

/* File: tb/rrs_exec_checker.sv */
// Checker for the bus handshake, stack link and sleep ports of rrs_exec.
// Assumes it is bound onto rrs_exec from the testbench top file.
`timescale 1ns/10ps
module rrs_exec_checker (
    input wire core_clk_i,
    input wire sys_rst_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire avs_waitrequest_o,
    input wire [14:0] stack_top_i,
    input wire stack_pop_o,
    input wire [14:0] pc_o,
    input wire halted_o,
    input wire osc_stop_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    wire req;
    assign req = avs_read_i | avs_write_i;
    ////////////////////////////////////////////////////////////////////////
    chk_pop_loads_pc: assert property (
        stack_pop_o |-> ##2 pc_o == $past(stack_top_i))
        else $error("pc not loaded from stack top");
    chk_pop_single: assert property (
        stack_pop_o |=> !stack_pop_o)
        else $error("stack pop longer than one cycle");
    chk_pc_source: assert property (
        $changed(pc_o) |-> $past(stack_pop_o, 2) ||
            pc_o == $past(pc_o) + 15'h1)
        else $error("pc moved without a pop or a single step");
    chk_halt_sticky: assert property (
        halted_o |=> halted_o)
        else $error("halt left without reset");
    chk_osc_halt: assert property (
        osc_stop_o == halted_o)
        else $error("oscillator stop differs from halt");
    chk_halt_frozen: assert property (
        halted_o && $past(halted_o) |-> $stable(pc_o) && !stack_pop_o)
        else $error("core active while halted");
    chk_wait_rise: assert property (
        req && !$past(req) |-> avs_waitrequest_o)
        else $error("no wait state on new request");
    chk_wait_bound: assert property (
        req |-> ##[0:8] !avs_waitrequest_o)
        else $error("request never answered");
endmodule // rrs_exec_checker

/* File: tb/tb_rrs_exec.sv */
// Self-checking bench for rrs_exec driven over its register bus.
// Assumes rrs_map.vh on the include path and the checker file compiled.
`timescale 1ns/10ps
`include "rrs_map.vh"
module tb_rrs_exec;
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] adr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [3:0] be = 4'hf;
    logic [14:0] top = 15'h0;
    wire [31:0] rdat;
    wire wreq, pop, halt, osc;
    wire [14:0] pc;
    int errors = 0;
    int checks = 0;
    always #10 clk = ~clk;
    rrs_exec uut (.core_clk_i(clk), .sys_rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdat),
        .avs_waitrequest_o(wreq), .stack_top_i(top), .stack_pop_o(pop),
        .pc_o(pc), .halted_o(halt), .osc_stop_o(osc));
    ////////////////////////////////////////////////////////////////////////
    task complete_run;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        wr <= 1'b0;
    endtask
    task chk_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        `CHK(rdat, e)
        rd <= 1'b0;
    endtask
    // Returns {zero, nibble carry, carry, result}.
    function automatic logic [10:0] model(input logic [2:0] op,
        input logic [2:0] st, input logic [7:0] a, f, k);
        logic [7:0] m;
        logic [8:0] r;
        m = (op == `RRS_OP_LSUB) ? k : f;
        r = {1'b0, m} - {1'b0, a};
        case (op)
            `RRS_OP_ROR: model = {st[2:1], f[0], st[0], f[7:1]};
            `RRS_OP_ROL: model = {st[2:1], f[7], f[6:0], st[0]};
            default: model = {r[7:0] == 8'h00, m[3:0] >= a[3:0],
                ~r[8], r[7:0]};
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial begin : main
        logic [2:0] op, st;
        logic [7:0] a, f, k;
        logic [6:0] fa;
        logic d, sel;
        logic [10:0] m;
        logic [14:0] pc_e;
        logic [31:0] v;
        int i;
        v = $urandom(32'h4e25);
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_rd(`RRS_OFS_STATUS, 32'h18);
        chk_rd(`RRS_OFS_PC, 32'h0);
        bus_wr(8'h1c, 32'hffffffff);
        chk_rd(8'h1c, 32'h0);
        pc_e = 15'h0;
        $display("test reset done");
        for (i = 0; i < 40; i++) begin
            op = (i % 4 < 2) ? 3'(2 + i % 4) : 3'(3 + i % 4);
            st = 3'($urandom);
            a = 8'($urandom);
            f = 8'($urandom);
            k = 8'($urandom);
            fa = 7'($urandom);
            d = 1'($urandom);
            if (i == 2)
                a = k;
            if (i == 3)
                a = f;
            if (i == 7) begin
                fa = 7'h7f;
                a = 8'h01;
                f = 8'h00;
                k = 8'h00;
            end
            bus_wr(`RRS_OFS_FPTR, {25'h0, fa});
            bus_wr(`RRS_OFS_FDATA, {24'h0, f});
            bus_wr(`RRS_OFS_ACC, {24'h0, a});
            bus_wr(`RRS_OFS_STATUS, {29'h0, st});
            bus_wr(`RRS_OFS_CMD, {8'h0, k, 5'h0, fa, d, op});
            m = model(op, st, a, f, k);
            sel = d && op != `RRS_OP_LSUB;
            pc_e = pc_e + 15'h1;
            chk_rd(`RRS_OFS_ACC, {24'h0, sel ? a : m[7:0]});
            chk_rd(`RRS_OFS_FDATA, {24'h0, sel ? m[7:0] : f});
            chk_rd(`RRS_OFS_STATUS, {25'h0, 4'h3, m[10:8]});
            chk_rd(`RRS_OFS_PC, {17'h0, pc_e});
        end
        $display("test rotate and subtract done");
        for (i = 0; i < 3; i++) begin
            top <= (i == 0) ? 15'h7fff : 15'($urandom);
            bus_wr(`RRS_OFS_CMD, {29'h0, `RRS_OP_RET});
            pc_e = top;
            chk_rd(`RRS_OFS_PC, {17'h0, pc_e});
            chk_rd(`RRS_OFS_STATUS, {25'h0, 4'h3, m[10:8]});
        end
        $display("test return done");
        bus_wr(`RRS_OFS_CMD, {29'h0, 3'h7});
        chk_rd(`RRS_OFS_PC, {17'h0, pc_e});
        chk_rd(`RRS_OFS_STATUS, {25'h0, 4'h3, m[10:8]});
        $display("test unused code done");
        bus_wr(`RRS_OFS_CMD, {29'h0, `RRS_OP_SLEEP});
        chk_rd(`RRS_OFS_STATUS, {25'h0, 4'ha, m[10:8]});
        chk_rd(`RRS_OFS_WDOG, 32'h0);
        `CHK(osc, 1'b1)
        bus_wr(`RRS_OFS_CMD, {29'h0, `RRS_OP_ROL});
        chk_rd(`RRS_OFS_PC, {17'h0, pc_e + 15'h1});
        $display("test sleep done");
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chk_rd(`RRS_OFS_STATUS, 32'h18);
        `CHK(halt, 1'b0)
        $display("test second reset done");
        complete_run;
    end
    initial begin
        #400000;
        errors++;
        complete_run;
    end
endmodule // tb_rrs_exec
bind rrs_exec rrs_exec_checker chk (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o),
    .stack_top_i(stack_top_i),
    .stack_pop_o(stack_pop_o),
    .pc_o(pc_o),
    .halted_o(halted_o),
    .osc_stop_o(osc_stop_o)
);
